// ==== src/ssar_readout.sv ====
// Serial SUCCESSIVE_APPROX_LOGIC converter control and readout, plus a buffered copy of results.
// Assumes the master keeps select setup, acquisition and clock rate limits;
// the comparator output is produced by analog logic paced by the shift clock.
//
// Function
// - Select high means shutdown; select low means normal operation.
// - Select falling edge wakes the converter and starts acquisition and conversion.
// - Only the master shift clock, at most 4.8MHz, paces conversion and shifting.
// - Serial output changes on shift-clock falling edges, and clears to zero at once when select rises.
// - Serial output goes high impedance three system clocks after select rises, and stays so while it is high.
// - Frame is eight zeros, then the 16-bit result, MSB first.
// - Result is unipolar straight binary; zero input gives code zero.
// - Sixth falling edge after select falls ends acquisition and holds the sample.
// - Remaining frame edges perform successive approximation to 16 bits.
// - Clocks after the LSB give zeros and leave the converter alone.
// - Select rising mid-conversion aborts at once and enters shutdown.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ssar_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side, registered
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] wptr_nxt;
   logic [AW-1:0] rptr_r;
   logic [AW-1:0] rptr_nxt;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic ov_r;
   logic ov_nxt;
   logic [WIDTH-1:0] od_r;
   logic [WIDTH-1:0] od_nxt;
   logic push;
   logic pop;

   always_comb begin
      // Full only at DEPTH words; the output stage holds one more
      in_ready = (cnt_r != (AW+1)'(DEPTH));
      push = in_valid && in_ready;
      // Output stage reloads when empty or taken, keeping data on a flop
      pop = (cnt_r != '0) && (!ov_r || out_ready);
      wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
      rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
      od_nxt = pop ? mem[rptr_r] : od_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         ov_r <= 1'b0;
         od_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r <= cnt_nxt;
         ov_r <= ov_nxt;
         od_r <= od_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   assign out_valid = ov_r;
   assign out_data = od_r;
endmodule

////////////////////////////////////////////////////////////////////////////////
module ssar_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level from another domain in, retimed level out
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] q1_r;
   logic [WIDTH-1:0] q1_nxt;
   logic [WIDTH-1:0] q2_r;
   logic [WIDTH-1:0] q2_nxt;

   always_comb begin
      // First stage may go metastable, so only the second is read
      q1_nxt = d_in;
      q2_nxt = q1_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q1_r <= RST_VAL;
         q2_r <= RST_VAL;
      end else begin
         q1_r <= q1_nxt;
         q2_r <= q2_nxt;
      end
   end

   assign q_out = q2_r;
endmodule

////////////////////////////////////////////////////////////////////////////////
module ssar_readout (
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial link from the master
   input wire logic sclk,
   input wire logic cs_n,
   output logic sdo,
   output logic sdo_oe,
   // Analog front end
   input wire logic cmp_in,
   output ssar_pkg::ssar_analog_t analog_ctl,
   output logic power_on,
   // Buffered result stream
   output logic res_valid,
   input wire logic res_ready,
   output ssar_pkg::ssar_result_t res_data,
   output logic res_overrun
);
   import ssar_pkg::*;

   // Position of the result bit resolved at a given falling edge
   function automatic logic [3:0] bit_idx(input logic [4:0] e);
      bit_idx = 4'(SSAR_LSB_EDGE - e);
   endfunction

   function automatic logic in_data(input logic [4:0] e);
      in_data = (e >= SSAR_MSB_EDGE) && (e <= SSAR_LSB_EDGE);
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // Link domain: falling shift-clock edges; all but the finished result and its toggle cleared while select is high
   logic link_rst_n;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [4:0] edge_no;
   logic [15:0] code_r;
   logic [15:0] code_nxt;
   logic sdo_r;
   logic sdo_nxt;
   logic hold_r;
   logic hold_nxt;
   logic [15:0] res_r;
   logic [15:0] res_nxt;
   logic tgl_r;
   logic tgl_nxt;

   // Select high is the link reset: aborts at once, no clock needed
   assign link_rst_n = rst_n & ~cs_n;

   always_comb begin
      edge_no = cnt_r + 5'h01;
      // Saturate so trailing clocks cannot wrap into a new frame
      cnt_nxt = (cnt_r == SSAR_CNT_SAT) ? cnt_r : edge_no;
      hold_nxt = hold_r | (edge_no == SSAR_HOLD_EDGE);
      code_nxt = code_r;
      sdo_nxt = 1'b0;
      res_nxt = res_r;
      tgl_nxt = tgl_r;
      if (edge_no == SSAR_TRIAL_EDGE) begin
         code_nxt = SSAR_MSB_TRIAL;
      end
      if (in_data(edge_no) && cnt_r != SSAR_CNT_SAT) begin
         // Comparator high keeps the trial bit: straight binary code
         code_nxt[bit_idx(edge_no)] = cmp_in;
         if (bit_idx(edge_no) != 4'h0) begin
            code_nxt[bit_idx(edge_no) - 4'h1] = 1'b1;
         end
         sdo_nxt = cmp_in;
      end
      if (edge_no == SSAR_LSB_EDGE) begin
         res_nxt = {code_r[15:1], cmp_in};
         tgl_nxt = ~tgl_r;
      end
   end

   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cnt_r <= SSAR_CNT_RST;
         code_r <= SSAR_CODE_RST;
         sdo_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         code_r <= code_nxt;
         sdo_r <= sdo_nxt;
         hold_r <= hold_nxt;
      end
   end

   // Finished result and its event toggle survive select high on purpose
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         res_r <= SSAR_CODE_RST;
         tgl_r <= 1'b0;
      end else begin
         res_r <= res_nxt;
         tgl_r <= tgl_nxt;
      end
   end

   assign sdo = sdo_r;
   assign analog_ctl.hold = hold_r;
   assign analog_ctl.dac_code = code_r;

   ///////////////////////////////////////////////////////////////////////////
   // System domain: select level, result event crossing, buffer
   logic cs_sync;
   logic tg_sync;
   logic oe_r;
   logic oe_nxt;
   logic tg_q3_r;
   logic pend_r;
   logic pend_nxt;
   logic ovr_r;
   logic ovr_nxt;
   logic fifo_ready;
   logic [15:0] cap_r;
   logic [15:0] cap_nxt;
   logic new_res;

   ssar_sync #(
      .WIDTH(1),
      .RST_VAL(1'h1)
   ) u_cs_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d_in(cs_n),
      .q_out(cs_sync)
   );

   ssar_sync #(
      .WIDTH(1),
      .RST_VAL(1'h0)
   ) u_tg_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d_in(tgl_r),
      .q_out(tg_sync)
   );

   always_comb begin
      // Enable follows synchronised select; the data pin floats from the third system clock after select rises
      oe_nxt = ~cs_sync;
      new_res = tg_sync ^ tg_q3_r;
      cap_nxt = new_res ? res_r : cap_r;
      // Buffer back-pressure holds the pending word; a newer word replaces it
      pend_nxt = new_res | (pend_r & ~fifo_ready);
      ovr_nxt = ovr_r | (new_res & pend_r & ~fifo_ready);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_r <= 1'b0;
         tg_q3_r <= 1'b0;
         pend_r <= 1'b0;
         ovr_r <= 1'b0;
         cap_r <= SSAR_CODE_RST;
      end else begin
         oe_r <= oe_nxt;
         tg_q3_r <= tg_sync;
         pend_r <= pend_nxt;
         ovr_r <= ovr_nxt;
         // Link holds res_r for a whole frame, so a late capture is safe
         cap_r <= cap_nxt;
      end
   end

   assign sdo_oe = oe_r;
   assign power_on = oe_r;
   assign res_overrun = ovr_r;

   ssar_fifo #(
      .WIDTH(SSAR_RES_BITS),
      .DEPTH(SSAR_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(pend_r),
      .in_ready(fifo_ready),
      .in_data(cap_r),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data.code)
   );
endmodule

`default_nettype wire

// ==== inc/ssar_pkg.sv ====
// Shared constants and carrier types for the serial SUCCESSIVE_APPROX_LOGIC converter readout.
// Assumes one system clock of 40 MHz and a master-driven shift clock.
package ssar_pkg;
   // Frame geometry, counted in shift-clock falling edges after select falls
   localparam int unsigned SSAR_RES_BITS = 16;
   localparam int unsigned SSAR_LEAD_ZEROS = 8;
   localparam logic [4:0] SSAR_HOLD_EDGE = 5'h06;
   localparam logic [4:0] SSAR_TRIAL_EDGE = 5'h07;
   localparam logic [4:0] SSAR_MSB_EDGE = 5'h08;
   localparam logic [4:0] SSAR_LSB_EDGE = 5'h17;
   localparam logic [4:0] SSAR_FRAME_EDGES = 5'h18;
   localparam logic [4:0] SSAR_CNT_SAT = 5'h19;
   // Reset values and the first trial code
   localparam logic [4:0] SSAR_CNT_RST = 5'h00;
   localparam logic [15:0] SSAR_CODE_RST = 16'h0000;
   localparam logic [15:0] SSAR_MSB_TRIAL = 16'h8000;
   // Link timing as the master must keep it, and the system clock period
   localparam real SSAR_SCLK_MAX_MHZ = 4.8;
   localparam int unsigned SSAR_ACQ_TIME_NS = 1100;
   localparam int unsigned SSAR_CSW_TIME_NS = 50;
   localparam int unsigned SSAR_CLK_PERIOD_NS = 25;
   localparam int unsigned SSAR_CSW_CYC =
      (SSAR_CSW_TIME_NS + SSAR_CLK_PERIOD_NS - 1) / SSAR_CLK_PERIOD_NS;
   // Result buffer
   localparam int unsigned SSAR_FIFO_DEPTH = 32;

   typedef struct packed {
      logic [15:0] code;
   } ssar_result_t;

   typedef struct packed {
      logic hold;
      logic [15:0] dac_code;
   } ssar_analog_t;
endpackage

// ==== sim/ssar_master.sv ====
// Serial master model for the converter link.
// Assumes the bench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
module ssar_master (
   // Link
   output logic sclk,
   output logic cs_n,
   input wire logic sdo_w
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   // Clock stands low outside frames
   task automatic frame(input int n, output logic [31:0] rd);
      rd = '0;
      cs_n = 1'b0;
      #800; // Long acquisition
      for (int i = 0; i < n; i++) begin
         #32 sclk = 1'b1;
         rd = {rd[30:0], sdo_w};
         #32 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      #100;
   endtask
endmodule
`default_nettype wire

// ==== sim/ssar_readout_asserts.sv ====
// Port checker for the converter readout.
// Assumes it is bound to ssar_readout.
`timescale 1ns/1ps
`default_nettype none
module ssar_readout_asserts (
   // Clock, reset
   input wire logic clk,
   input wire logic rst_n,
   // Link and analog
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire ssar_pkg::ssar_analog_t analog_ctl,
   input wire logic power_on
);
   import ssar_pkg::*;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   // Saturates so long frames stay in range
   always_comb begin
      cnt_nxt = (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h01;
   end
   always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
      end else if (cs_n) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   property p_oe_off;
      @(posedge clk) disable iff (!rst_n) cs_n [*4] |-> !sdo_oe && !power_on;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("driving in shutdown");
   property p_oe_on;
      @(posedge clk) disable iff (!rst_n) !cs_n [*4] |-> sdo_oe && power_on;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("not awake");
   property p_lead;
      @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r < 5'h08 |-> !sdo;
   endproperty
   a_lead: assert property (p_lead)
      else $error("lead bit not zero");
   property p_bit;
      @(posedge sclk) disable iff (!rst_n || cs_n)
         cnt_r inside {[8:23]} |-> sdo == analog_ctl.dac_code[5'h17 - cnt_r];
   endproperty
   a_bit: assert property (p_bit)
      else $error("bit differs from code");
   property p_trail;
      @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r > 5'h17 |-> !sdo;
   endproperty
   a_trail: assert property (p_trail)
      else $error("trailing bit not zero");
   property p_hold;
      @(posedge sclk) disable iff (!rst_n || cs_n) analog_ctl.hold == (cnt_r > 5'h05);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold at wrong edge");
   property p_trial;
      @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r == 5'h07 |-> analog_ctl.dac_code == 16'h8000;
   endproperty
   a_trial: assert property (p_trial)
      else $error("first trial wrong");
   property p_fall;
      @(posedge clk) disable iff (!rst_n) sclk && $past(sclk) && !cs_n |-> $stable(sdo);
   endproperty
   a_fall: assert property (p_fall)
      else $error("sdo moved while clock high");
   property p_clear;
      @(posedge clk) disable iff (!rst_n) cs_n |-> !sdo && !analog_ctl.hold && analog_ctl.dac_code == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("link not cleared");
endmodule
bind ssar_readout ssar_readout_asserts ssar_readout_asserts_inst (.clk, .rst_n, .sclk, .cs_n, .sdo, .sdo_oe,
   .analog_ctl, .power_on);
`default_nettype wire

// ==== sim/ssar_readout_test.sv ====
// Bench: frames, abort, buffer fill and drain.
// Assumes ssar_master drives the link.
`timescale 1ns/1ps
`default_nettype none
module ssar_readout_test;
   import ssar_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic res_ready = 1'b0;
   logic [15:0] target = 16'h0000;
   logic sclk, cs_n, sdo, sdo_oe, power_on, res_valid, res_overrun, cmp_in, sdo_w;
   ssar_analog_t analog_ctl;
   ssar_result_t res_data;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rd;
   // Pull-up on the released wire
   assign sdo_w = sdo_oe ? sdo : 1'b1;
   assign cmp_in = target >= analog_ctl.dac_code;
   always #12.5 clk = ~clk;
   ssar_readout ssar_readout_inst (.clk, .rst_n, .sclk, .cs_n, .sdo, .sdo_oe, .cmp_in, .analog_ctl,
      .power_on, .res_valid, .res_ready, .res_data, .res_overrun);
   ssar_master ssar_master_inst (.sclk, .cs_n, .sdo_w);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic pop(output logic [15:0] d);
      @(posedge clk);
      repeat (40) if (res_valid !== 1'b1) @(posedge clk);
      d = (res_valid === 1'b1) ? res_data.code : 'x;
      res_ready <= 1'b1;
      @(posedge clk);
      res_ready <= 1'b0;
   endtask
   task automatic t_frame(input logic [15:0] code, input int n);
      logic [15:0] d;
      target = code;
      ssar_master_inst.frame(n, rd);
      check("frame", rd, {8'h00, code, 8'h00} >> (32 - n));
      pop(d);
      check("result", d, code);
   endtask
   task automatic t_abort();
      target = 16'h1234;
      ssar_master_inst.frame(12, rd);
      repeat (40) @(posedge clk);
      check("aborted", {res_valid, sdo_oe, power_on}, 3'b000);
      check("no overrun", res_overrun, 1'b0);
   endtask
   // Consumer stalls through 35 frames
   task automatic t_fill();
      logic [15:0] d;
      for (int i = 0; i < 35; i++) begin
         target = 16'(i);
         ssar_master_inst.frame(24, rd);
      end
      check("overrun", res_overrun, 1'b1);
      for (int i = 0; i < 34; i++) begin
         pop(d);
         check("drain", d, (i < 33) ? i : 34);
      end
      repeat (10) @(posedge clk);
      check("empty", res_valid, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_frame(16'h0000, 24);
      t_frame(16'hffff, 28);
      t_frame(16'ha5c3, 24);
      t_abort();
      t_frame(16'h5a3c, 32);
      t_fill();
      end_of_test();
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         end_of_test();
      end
   end
endmodule
`default_nettype wire
